// ===== crf_top.sv
// Functional notes
// - 8-bit accumulator holds operands and results
// - 16-bit index from high and low bytes
// - reset loads stack pointer with 00ff
// - rsp sets sp low byte ff only
// - push decrements, pull increments stack pointer
// - sp-relative address adds 8/16-bit offset
// - pc increments on fetch, jumps load it
// - reset loads pc from vector fffe:ffff
// - ccr bits 6 and 5 read one
// - overflow flag set on signed overflow
// - half carry from bit 3 on adds
// - mask blocks irqs, set after stacking
// - interrupt entry does not stack index high
// - highest priority pending irq served first
// - rti restores ccr including mask, and pc
// - reset sets mask, cli, wait or stop clear it, rti reloads it
// - negative flag copies result bit 7
// - zero flag set for 00 result
// - carry from bit 7 or borrow, shifts
// - wait clears mask, reset exit sets
// - stop clears mask, restart after delay
// - stop exit by irq keeps mask clear
// - stop recovery 32 or 4096 cycles
//
// Purpose: cpu programmer register set behind an axi4-lite slave
// Assumes: one clock; vector and irq lines supplied by the core
// Notes:   commands are issued by writing the command register
`timescale 1ns/1ps
module crf_top
   import crf_pkg::*;
#(
   parameter int IRQ_W    = 8,
   parameter int LONG_CYC = STOP_LONG_CYC
)(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // core side
   input  wire logic [15:0]       reset_vector,
   input  wire logic [IRQ_W-1:0]  irq_pending,
   output logic [IRQ_W-1:0]       irq_grant,
   output logic                   cpu_clock_run,
   output logic [15:0]            operand_addr
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]    acc_q;
   logic [7:0]    idx_hi_q;
   logic [7:0]    idx_lo_q;
   logic [15:0]   sp_q;
   logic [15:0]   pc_q;
   logic [7:0]    ccr_q;
   logic [15:0]   opnd_q;
   logic [15:0]   result_q;
   logic          cfg_short_q;
   logic          aw_hold_q;
   logic          w_hold_q;
   logic [7:0]    aw_addr_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;
   logic [15:0]   rec_cnt_q;
   logic          boot_q;
   crf_state_type state_q;
   logic [IRQ_W-1:0] grant_q;

   logic          wr_fire;
   logic          cmd_fire;
   crf_cmd_type   cmd;
   logic [8:0]    sum9;
   logic [4:0]    half5;
   logic [7:0]    res8;
   logic          res_valid;
   logic          v_new;
   logic          c_new;
   logic          h_new;
   logic          h_upd;
   logic          v_upd;
   logic          c_upd;
   logic [IRQ_W-1:0] pick;

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   // address and data are latched separately so either may come first
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign cmd_fire = wr_fire && aw_addr_q == OFS_CMD && w_strb_q[0]
                     && state_q == ST_RUN;
   assign cmd      = crf_cmd_type'(w_data_q[4:0]);

   // ------------------------------------------------------------
   // alu
   // ------------------------------------------------------------
   always_comb begin
      sum9      = 9'h000;
      half5     = 5'h00;
      res8      = acc_q;
      res_valid = 1'b0;
      v_new     = 1'b0;
      c_new     = ccr_q[CCR_C];
      h_new     = ccr_q[CCR_H];
      h_upd     = 1'b0;
      v_upd     = 1'b0;
      c_upd     = 1'b0;
      if (cmd_fire) begin
         case (cmd)
            CMD_ADD, CMD_ADC: begin
               sum9  = {1'b0, acc_q} + {1'b0, opnd_q[7:0]}
                       + {8'h00, cmd == CMD_ADC && ccr_q[CCR_C]};
               half5 = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]}
                       + {4'h0, cmd == CMD_ADC && ccr_q[CCR_C]};
               res8  = sum9[7:0];
               c_new = sum9[8];
               h_new = half5[4];
               v_new = (acc_q[7] == opnd_q[7]) && (res8[7] != acc_q[7]);
               res_valid = 1'b1;
               h_upd = 1'b1;
               v_upd = 1'b1;
               c_upd = 1'b1;
            end
            CMD_SUB: begin
               sum9  = {1'b0, acc_q} - {1'b0, opnd_q[7:0]};
               res8  = sum9[7:0];
               c_new = sum9[8];
               v_new = (acc_q[7] != opnd_q[7]) && (res8[7] != acc_q[7]);
               res_valid = 1'b1;
               v_upd = 1'b1;
               c_upd = 1'b1;
            end
            CMD_AND: begin
               res8  = acc_q & opnd_q[7:0];
               res_valid = 1'b1;
               v_upd = 1'b1;
            end
            CMD_LDA: begin
               res8  = opnd_q[7:0];
               res_valid = 1'b1;
               v_upd = 1'b1;
            end
            CMD_ASL: begin
               res8  = {acc_q[6:0], 1'b0};
               c_new = acc_q[7];
               v_new = acc_q[7] ^ acc_q[6];
               res_valid = 1'b1;
               v_upd = 1'b1;
               c_upd = 1'b1;
            end
            CMD_ROR: begin
               res8  = {ccr_q[CCR_C], acc_q[7:1]};
               c_new = acc_q[0];
               v_new = ccr_q[CCR_C] ^ acc_q[0];
               res_valid = 1'b1;
               v_upd = 1'b1;
               c_upd = 1'b1;
            end
            default: begin
               res_valid = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // accumulator and index
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_q    <= 8'h00;
         idx_hi_q <= 8'h00;
         idx_lo_q <= 8'h00;
      end else if (res_valid) begin
         acc_q <= res8;
      end else if (cmd_fire && cmd == CMD_PULL) begin
         idx_hi_q <= opnd_q[7:0];
      end else if (wr_fire && aw_addr_q == OFS_INDEX
                   && state_q == ST_RUN) begin
         if (w_strb_q[0]) idx_lo_q <= w_data_q[7:0];
         if (w_strb_q[1]) idx_hi_q <= w_data_q[15:8];
      end else if (wr_fire && aw_addr_q == OFS_ACC && w_strb_q[0]
                   && state_q == ST_RUN) begin
         acc_q <= w_data_q[7:0];
      end
   end

   // ------------------------------------------------------------
   // stack pointer and program counter
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_q <= SP_RESET;
      end else if (cmd_fire) begin
         case (cmd)
            CMD_RSP:  sp_q <= {sp_q[15:8], SP_LOW_RST};
            CMD_PUSH: sp_q <= sp_q - 16'h0001;
            CMD_PULL: sp_q <= sp_q + 16'h0001;
            // irq stacks five bytes, not the index high byte
            CMD_IRQ:  sp_q <= sp_q - 16'h0005;
            CMD_RTI:  sp_q <= sp_q + 16'h0005;
            default:  sp_q <= sp_q;
         endcase
      end
   end

   // pc vector is fetched in the first cycle after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_q <= 1'b1;
         pc_q   <= 16'h0000;
      end else if (boot_q) begin
         boot_q <= 1'b0;
         pc_q   <= reset_vector;
      end else if (cmd_fire) begin
         case (cmd)
            CMD_FETCH: pc_q <= pc_q + 16'h0001;
            CMD_JUMP, CMD_IRQ, CMD_RTI: pc_q <= opnd_q;
            default:   pc_q <= pc_q;
         endcase
      end
   end

   // ------------------------------------------------------------
   // operand address
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operand_addr <= 16'h0000;
      end else if (cmd_fire && cmd == CMD_SPAD8) begin
         operand_addr <= sp_q + {8'h00, opnd_q[7:0]};
      end else if (cmd_fire && cmd == CMD_SPA16) begin
         operand_addr <= sp_q + opnd_q;
      end else if (cmd_fire && cmd == CMD_IXAD) begin
         operand_addr <= {idx_hi_q, idx_lo_q} + opnd_q;
      end
   end

   // ------------------------------------------------------------
   // condition codes
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccr_q <= CCR_RESET;
      end else begin
         if (res_valid) begin
            ccr_q[CCR_N] <= res8[7];
            ccr_q[CCR_Z] <= res8 == ZERO_BYTE;
            if (v_upd) ccr_q[CCR_V] <= v_new;
            if (h_upd) ccr_q[CCR_H] <= h_new;
            if (c_upd) ccr_q[CCR_C] <= c_new;
         end
         if (cmd_fire) begin
            case (cmd)
               CMD_IRQ:  ccr_q[CCR_I] <= 1'b1;
               CMD_RTI:  ccr_q <= opnd_q[7:0];
               CMD_CLI, CMD_WAIT, CMD_STOP:
                         ccr_q[CCR_I] <= 1'b0;
               default:  ccr_q[CCR_I] <= ccr_q[CCR_I];
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // wait, stop, recovery
   // ------------------------------------------------------------
   // irq wake keeps the mask clear; reset or the irq command sets it again, rti reloads it from the operand
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q   <= ST_RUN;
         rec_cnt_q <= 16'h0000;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (cmd_fire && cmd == CMD_WAIT) state_q <= ST_WAIT;
               if (cmd_fire && cmd == CMD_STOP) state_q <= ST_STOP;
            end
            ST_WAIT: if (|irq_pending) state_q <= ST_RUN;
            ST_STOP: if (|irq_pending) begin
               state_q   <= ST_RECOV;
               rec_cnt_q <= cfg_short_q ? 16'(STOP_SHORT_CYC - 1)
                                        : 16'(LONG_CYC - 1);
            end
            ST_RECOV: begin
               if (rec_cnt_q == 16'h0000) state_q <= ST_RUN;
               else rec_cnt_q <= rec_cnt_q - 16'h0001;
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end
   assign cpu_clock_run = state_q == ST_RUN;

   // ------------------------------------------------------------
   // interrupt priority, low index wins
   // ------------------------------------------------------------
   assign pick = irq_pending & (~irq_pending + IRQ_W'(1));
   always_ff @(posedge aclk) begin
      if (!aresetn) grant_q <= '0;
      else if (cmd_fire && cmd == CMD_IRQ && !ccr_q[CCR_I])
         grant_q <= pick;
      else grant_q <= '0;
   end
   assign irq_grant = grant_q;

   // ------------------------------------------------------------
   // config, operand and result registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opnd_q      <= 16'h0000;
         cfg_short_q <= 1'b0;
         result_q    <= 16'h0000;
      end else begin
         if (wr_fire && aw_addr_q == OFS_OPND) begin
            if (w_strb_q[0]) opnd_q[7:0]  <= w_data_q[7:0];
            if (w_strb_q[1]) opnd_q[15:8] <= w_data_q[15:8];
         end
         if (wr_fire && aw_addr_q == OFS_CFG && w_strb_q[0])
            cfg_short_q <= w_data_q[0];
         if (res_valid) result_q <= {8'h00, res8};
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            OFS_ACC:    s_axi_rdata <= {24'h00_0000, acc_q};
            OFS_INDEX:  s_axi_rdata <= {16'h0000, idx_hi_q, idx_lo_q};
            OFS_SP:     s_axi_rdata <= {16'h0000, sp_q};
            OFS_PC:     s_axi_rdata <= {16'h0000, pc_q};
            OFS_CCR:    s_axi_rdata <= {24'h00_0000, ccr_q[7],
                                        2'b11, ccr_q[4:0]};
            OFS_OPND:   s_axi_rdata <= {16'h0000, opnd_q};
            OFS_RESULT: s_axi_rdata <= {16'h0000, result_q};
            OFS_STATUS: s_axi_rdata <= {28'h000_0000, state_q};
            OFS_CFG:    s_axi_rdata <= {31'h0000_0000, cfg_short_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ===== crf_pkg.sv
// Purpose: shared constants and types for the cpu register file
// Assumes: one clock, synchronous active-low reset
// Notes:   byte addresses of the axi4-lite register window
package crf_pkg;

   // ------------------------------------------------------------
   // register window offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ACC     = 8'h00;
   localparam logic [7:0] OFS_INDEX   = 8'h04;
   localparam logic [7:0] OFS_SP      = 8'h08;
   localparam logic [7:0] OFS_PC      = 8'h0C;
   localparam logic [7:0] OFS_CCR     = 8'h10;
   localparam logic [7:0] OFS_OPND    = 8'h14;
   localparam logic [7:0] OFS_CMD     = 8'h18;
   localparam logic [7:0] OFS_RESULT  = 8'h1C;
   localparam logic [7:0] OFS_STATUS  = 8'h20;
   localparam logic [7:0] OFS_CFG     = 8'h24;

   // ------------------------------------------------------------
   // reset values and fixed patterns
   // ------------------------------------------------------------
   localparam logic [15:0] SP_RESET    = 16'h00FF;
   localparam logic [7:0]  SP_LOW_RST  = 8'hFF;
   localparam logic [15:0] VEC_RESET_H = 16'hFFFE;
   localparam logic [15:0] VEC_RESET_L = 16'hFFFF;
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;
   localparam logic [7:0]  CCR_RESET   = 8'h68;

   // ccr bit positions
   localparam int CCR_C  = 0;
   localparam int CCR_Z  = 1;
   localparam int CCR_N  = 2;
   localparam int CCR_I  = 3;
   localparam int CCR_H  = 4;
   localparam int CCR_O5 = 5;
   localparam int CCR_O6 = 6;
   localparam int CCR_V  = 7;

   // stop recovery in oscillator cycles
   localparam int STOP_SHORT_CYC = 32;
   localparam int STOP_LONG_CYC  = 4096;

   // ------------------------------------------------------------
   // commands written to the command register
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      CMD_NOP   = 5'h00,
      CMD_ADD   = 5'h01,
      CMD_ADC   = 5'h02,
      CMD_SUB   = 5'h03,
      CMD_AND   = 5'h04,
      CMD_LDA   = 5'h05,
      CMD_ASL   = 5'h06,
      CMD_ROR   = 5'h07,
      CMD_RSP   = 5'h08,
      CMD_PUSH  = 5'h09,
      CMD_PULL  = 5'h0A,
      CMD_FETCH = 5'h0B,
      CMD_JUMP  = 5'h0C,
      CMD_IRQ   = 5'h0D,
      CMD_RTI   = 5'h0E,
      CMD_CLI   = 5'h0F,
      CMD_WAIT  = 5'h10,
      CMD_STOP  = 5'h11,
      CMD_SPAD8 = 5'h12,
      CMD_SPA16 = 5'h13,
      CMD_IXAD  = 5'h14
   } crf_cmd_type;

   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_STOP  = 4'b0100,
      ST_RECOV = 4'b1000
   } crf_state_type;

   typedef struct packed {
      logic [7:0]  acc;
      logic [15:0] index;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0]  condition_code_register;
   } crf_regs_type;

endpackage

// ===== crf_chk.sv
// Purpose: bus and core-side relations of the cpu register file
// Assumes: one clock, synchronous active-low reset
// Notes:   watches top-level ports only
`timescale 1ns/1ps
module crf_chk
   import crf_pkg::*;
#(
   parameter int IRQ_W = 8
)(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // register bus
   input wire logic [7:0]       s_axi_araddr,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   input wire logic             s_axi_rvalid,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_bvalid,
   // core side
   input wire logic [IRQ_W-1:0] irq_pending,
   input wire logic [IRQ_W-1:0] irq_grant,
   input wire logic             cpu_clock_run
);
   // ------------------------------------------------------------
   // helper: address of the read under way
   // ------------------------------------------------------------
   logic [7:0] raddr_q;
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         raddr_q <= s_axi_araddr;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_ccr_fixed: assert property (s_axi_rvalid && raddr_q == OFS_CCR
      && s_axi_rresp == 2'b00 |-> s_axi_rdata[6:5] == 2'b11)
      else $error("ccr fixed bits not one");
   a_grant_hot: assert property (irq_grant != '0 |-> $onehot(irq_grant))
      else $error("grant not one-hot");
   a_grant_prio: assert property (irq_grant != '0 |->
      irq_grant == ($past(irq_pending) & (~$past(irq_pending) + 1'b1)))
      else $error("grant not highest priority");
   a_grant_pulse: assert property (irq_grant != '0 |=> irq_grant == '0)
      else $error("grant longer than one cycle");
   a_grant_write: assert property (irq_grant != '0 |-> $rose(s_axi_bvalid))
      else $error("grant without command");
   a_clk_stops: assert property ($fell(cpu_clock_run) |->
      $rose(s_axi_bvalid))
      else $error("clock stopped without command");
   a_bad_addr: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr > OFS_CFG |=> s_axi_rvalid && s_axi_rresp == 2'b10
      && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
      else $error("write response not okay");
   a_ar_refused: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("address taken during read data");
endmodule

bind crf_top crf_chk #(.IRQ_W(IRQ_W)) u_crf_chk (.*);

// ===== crf_core_model.sv
// Purpose: core-side model feeding vector and interrupt levels
// Assumes: bench raises request levels; grant serves one line
// Notes:   a served line stays quiet until its request drops
`timescale 1ns/1ps
module crf_core_model
   import crf_pkg::*;
#(
   parameter int          IRQ_W = 8,
   parameter logic [15:0] VEC   = 16'h8A40
)(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // requests from the bench
   input wire logic [IRQ_W-1:0] irq_req,
   // core side of the block
   input wire logic [IRQ_W-1:0] irq_grant,
   output logic [IRQ_W-1:0]     irq_pending,
   output logic [15:0]          reset_vector
);
   // ------------------------------------------------------------
   // lines already served by a grant
   // ------------------------------------------------------------
   logic [IRQ_W-1:0] served_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         served_q <= '0;
      end else begin
         served_q <= (served_q | irq_grant) & irq_req;
      end
   end
   // vector word read in the first cycle after reset release
   assign reset_vector = VEC;
   // levels hold until served, so priority is visible
   assign irq_pending = irq_req & ~served_q;
endmodule

// ===== crf_top_bench.sv
// Purpose: self-checking bench for the cpu register file
// Assumes: short long-recovery count for run time
// Notes:   commands issued through the axi4-lite window
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module crf_top_bench;
   import crf_pkg::*;
   localparam int          IRQ_W = 8;
   localparam int          LONG  = 40;
   localparam logic [15:0] VEC   = 16'h8A40;
   logic             aclk = 0;
   logic             aresetn = 0;
   logic [7:0]       s_axi_awaddr = '0;
   logic [7:0]       s_axi_araddr = '0;
   logic             s_axi_awvalid = 0;
   logic             s_axi_wvalid = 0;
   logic             s_axi_bready = 0;
   logic             s_axi_arvalid = 0;
   logic             s_axi_rready = 0;
   logic [31:0]      s_axi_wdata = '0;
   logic [3:0]       s_axi_wstrb = '0;
   logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic             s_axi_arready, s_axi_rvalid, cpu_clock_run;
   logic [1:0]       s_axi_bresp, s_axi_rresp, r;
   logic [31:0]      s_axi_rdata, d;
   logic [15:0]      reset_vector, operand_addr, s0;
   logic [IRQ_W-1:0] irq_pending, irq_grant, gseen;
   logic [IRQ_W-1:0] irq_req = '0;
   int               bad_count = 0;
   int               n_compared = 0;

   always #5 aclk = ~aclk;
   always @(posedge aclk) if (irq_grant != '0) gseen <= irq_grant;

   crf_top #(.IRQ_W(IRQ_W), .LONG_CYC(LONG)) u_crf_top (.*);
   crf_core_model #(.IRQ_W(IRQ_W), .VEC(VEC)) u_crf_core_model (.*);

   // ------------------------------------------------------------
   // bus tasks: sample at the falling edge, act after the rising
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge aclk);
         if (ta) begin s_axi_awvalid <= 0; pa = 0; end
         if (tw) begin s_axi_wvalid <= 0; pw = 0; end
      end
      ta = 0;
      while (!ta) begin @(negedge aclk); ta = s_axi_bvalid; @(posedge aclk); end
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      logic t;
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!t) begin @(negedge aclk); t = s_axi_arready; @(posedge aclk); end
      s_axi_arvalid <= 0;
      t = 0;
      while (!t) begin
         @(negedge aclk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task automatic op(input crf_cmd_type c, input logic [15:0] o);
      wr(OFS_OPND, {16'h0000, o});
      wr(OFS_CMD, {27'h000_0000, c});
   endtask
   task automatic do_reset;
      aresetn <= 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
   endtask
   task automatic wake(input int n);
      int c;
      c = 0;
      irq_req <= 8'h01;
      do begin @(negedge aclk); c++; end while (!cpu_clock_run && c < 9000);
      @(posedge aclk);
      irq_req <= '0;
      `CHK(c >= n && c <= n + 4, 1'b1)
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(OFS_SP); `CHK(d[15:0], 16'h00FF)
      rd(OFS_PC); `CHK(d[15:0], VEC)
      rd(OFS_CCR); `CHK(d[7:0], 8'h68)
      rd(8'h40); `CHK({r, d}, {2'b10, 32'h0})
      $display("test reset done");
   endtask
   task automatic t_alu;
      op(CMD_LDA, 16'h007F); rd(OFS_ACC); `CHK(d[7:0], 8'h7F)
      op(CMD_ADD, 16'h0001); rd(OFS_CCR); `CHK(d[7:0], 8'hFC)
      op(CMD_ADD, 16'h0080); rd(OFS_CCR); `CHK(d[7:0], 8'hEB)
      op(CMD_SUB, 16'h0001); rd(OFS_CCR); `CHK(d[7:0], 8'h6D)
      op(CMD_AND, 16'h0000); rd(OFS_CCR); `CHK(d[7:0], 8'h6B)
      op(CMD_NOP, 16'h0000); rd(OFS_CCR); `CHK(d[7:0], 8'h6B)
      op(CMD_ADC, 16'h000F); rd(OFS_CCR); `CHK(d[7:0], 8'h78)
      op(CMD_LDA, 16'h0081); op(CMD_ASL, 16'h0000); rd(OFS_CCR);
      `CHK(d[0], 1'b1)
      op(CMD_ROR, 16'h0000); rd(OFS_ACC); `CHK(d[7:0], 8'h81)
      rd(OFS_RESULT); `CHK(d[15:0], 16'h0081)
      $display("test alu done");
   endtask
   task automatic t_addr;
      wr(OFS_INDEX, 32'h0000_ABCD); op(CMD_IXAD, 16'h0010);
      `CHK(operand_addr, 16'hABDD)
      op(CMD_PULL, 16'h0000); op(CMD_RSP, 16'h0000);
      rd(OFS_SP); `CHK(d[15:0], 16'h01FF)
      op(CMD_PUSH, 16'h0000); rd(OFS_SP); `CHK(d[15:0], 16'h01FE)
      op(CMD_PULL, 16'h0000); rd(OFS_SP); `CHK(d[15:0], 16'h01FF)
      op(CMD_SPAD8, 16'h0005); `CHK(operand_addr, 16'h0204)
      op(CMD_SPA16, 16'h0101); `CHK(operand_addr, 16'h0300)
      op(CMD_FETCH, 16'h0000); rd(OFS_PC); `CHK(d[15:0], VEC + 1'b1)
      op(CMD_JUMP, 16'h4000); rd(OFS_PC); `CHK(d[15:0], 16'h4000)
      $display("test address done");
   endtask
   task automatic t_irq;
      gseen = '0;
      irq_req <= 8'h06;
      op(CMD_IRQ, 16'h2000); `CHK(gseen, 8'h00)
      op(CMD_CLI, 16'h0000); rd(OFS_CCR); `CHK(d[3], 1'b0)
      rd(OFS_SP);
      s0 = d[15:0];
      op(CMD_IRQ, 16'h2000); `CHK(gseen, 8'h02)
      rd(OFS_SP); `CHK(d[15:0], s0 - 16'd5)
      rd(OFS_CCR); `CHK(d[3], 1'b1)
      rd(OFS_PC); `CHK(d[15:0], 16'h2000)
      op(CMD_RTI, 16'h3000); rd(OFS_CCR); `CHK(d[7:0], 8'h60)
      rd(OFS_SP); `CHK(d[15:0], s0)
      irq_req <= '0;
      $display("test interrupt done");
   endtask
   task automatic t_low;
      op(CMD_WAIT, 16'h0000);
      @(negedge aclk); `CHK(cpu_clock_run, 1'b0)
      @(posedge aclk);
      wake(1); rd(OFS_CCR); `CHK(d[3], 1'b0)
      wr(OFS_CFG, 32'h0000_0001); op(CMD_STOP, 16'h0000);
      rd(OFS_CCR); `CHK(d[3], 1'b0)
      wake(32);
      wr(OFS_CFG, 32'h0000_0000); op(CMD_STOP, 16'h0000);
      wake(LONG); rd(OFS_CCR); `CHK(d[3], 1'b0)
      op(CMD_WAIT, 16'h0000); do_reset;
      rd(OFS_CCR); `CHK(d[7:0], 8'h68)
      op(CMD_STOP, 16'h0000); do_reset;
      rd(OFS_CCR); `CHK(d[7:0], 8'h68)
      $display("test low power done");
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_reset;
      t_alu;
      t_addr;
      t_irq;
      t_low;
      close_out;
   end
   // the whole run needs well under 5000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      close_out;
   end
endmodule
